// ---- logic/flpci_pkg.sv ----
// Purpose: Shared constants for the flash LED pulse-count control interface.
// Assumes: Core clock of 200 MHz.
// Notes: Times are kept in their own unit; cycle counts derive from them.
package flpci_pkg;
  localparam int CLK_MHZ = 200;
  // Indicator pattern: on 1 us out of every 32 us.
  localparam int IND_ON_NS = 1000;
  localparam int IND_PERIOD_NS = 32000;
  localparam int IND_ON_CYC = (IND_ON_NS * CLK_MHZ + 999) / 1000;
  localparam int IND_PERIOD_CYC = (IND_PERIOD_NS * CLK_MHZ) / 1000;
  // One millisecond step of the timed indicator pulse.
  localparam int MS_US = 1000;
  localparam int MS_CYC = MS_US * CLK_MHZ;
  // Flash time limit.
  localparam int FLASH_LIMIT_MS = 800;
  localparam int FLASH_LIMIT_CYC = FLASH_LIMIT_MS * MS_CYC;
  // Window in which the timed indicator setup train must complete.
  localparam int SETUP_WIN_US = 128;
  localparam int SETUP_WIN_CYC = SETUP_WIN_US * CLK_MHZ;
  // Internal start delay for sequencing method A.
  localparam int START_DELAY_US = 10;
  localparam int START_DELAY_CYC = START_DELAY_US * CLK_MHZ;
  // Pulse count limits.
  localparam logic [4:0] NOISE_MAX = 5'h02;
  localparam logic [4:0] COUNT_SAT = 5'h11;
  localparam logic [4:0] TORCH_MIN = 5'h02;
  localparam logic [4:0] FLASH_MIN = 5'h06;
  // Current ratios.
  localparam logic [12:0] IND_RATIO = 13'h0034;
  localparam logic [12:0] TORCH_RATIO = 13'h0667;
  // Operating modes.
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_IND = 2'b01,
    MODE_TORCH = 2'b10,
    MODE_FLASH = 2'b11
  } flpci_mode_e;
endpackage

// ---- logic/flpci_sync.sv ----
// Purpose: Two-flop synchroniser for asynchronous pin inputs.
// Assumes: Inputs are slow levels that hold far longer than a clock period.
// Notes: Only the second stage leaves this module.
`timescale 1ns/1ps
module flpci_sync #(
  parameter int WIDTH = 4
) (
  // Clock and control
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Data
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      meta_r <= '0;
      o_q <= '0;
    end else if (i_ce) begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule

// ---- logic/flpci_top.sv ----
// Purpose: Decode the two control inputs of a flash LED driver into mode,
//   current ratio and the LED enable, with flash time limit.
// Assumes: Pins are asynchronous; i_multi_current selects the variant.
// Notes: Analog current scaling is outside; o_ratio is the sink ratio.
`timescale 1ns/1ps
module flpci_top #(
  parameter int MS_CYC = flpci_pkg::MS_CYC,
  parameter int FLASH_LIMIT_CYC = flpci_pkg::FLASH_LIMIT_CYC,
  parameter int SETUP_WIN_CYC = flpci_pkg::SETUP_WIN_CYC,
  parameter int START_DELAY_CYC = flpci_pkg::START_DELAY_CYC
) (
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Control pins
  input wire logic i_first_control_input,
  input wire logic i_second_control_input,
  input wire logic i_transmit_current_mask,
  input wire logic i_multi_current,
  // LED drive
  output logic o_led_on,
  output logic [1:0] o_mode,
  output logic [12:0] o_ratio,
  output logic o_current_reduced,
  // Status
  output logic o_method_b,
  output logic [4:0] o_pulse_count,
  output logic o_flash_timed_out
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_A_WAIT = 3'b001,
    ST_B_SETUP = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_DIRECT = 3'b100,
    ST_TIMED = 3'b101
  } flpci_state_e;

  function automatic logic [4:0] flpci_inc(input logic [4:0] n);
    flpci_inc = (n >= flpci_pkg::COUNT_SAT) ? n : n + 5'h01;
  endfunction

  function automatic flpci_pkg::flpci_mode_e flpci_decode(
    input logic [4:0] n);
    if (n < flpci_pkg::TORCH_MIN) flpci_decode = flpci_pkg::MODE_IND;
    else if (n < flpci_pkg::FLASH_MIN) flpci_decode = flpci_pkg::MODE_TORCH;
    else flpci_decode = flpci_pkg::MODE_FLASH;
  endfunction

  function automatic logic [12:0] flpci_ratio(input logic [4:0] n);
    case (n)
      5'h00, 5'h01: flpci_ratio = flpci_pkg::IND_RATIO;
      5'h02: flpci_ratio = 13'h01c0;
      5'h03: flpci_ratio = 13'h03a1;
      5'h04: flpci_ratio = 13'h0582;
      5'h05: flpci_ratio = 13'h0763;
      5'h06: flpci_ratio = 13'h0943;
      5'h07: flpci_ratio = 13'h0b24;
      5'h08: flpci_ratio = 13'h0d05;
      5'h09: flpci_ratio = 13'h0ee6;
      5'h0a: flpci_ratio = 13'h10c7;
      5'h0b: flpci_ratio = 13'h12a8;
      5'h0c: flpci_ratio = 13'h1489;
      5'h0d: flpci_ratio = 13'h1669;
      5'h0e: flpci_ratio = 13'h184a;
      5'h0f: flpci_ratio = 13'h1a2b;
      5'h10: flpci_ratio = 13'h1c0c;
      default: flpci_ratio = 13'h1de2;
    endcase
  endfunction

  logic [3:0] pins_q;
  logic first_in, second_in, mask, multi;
  logic first_d_r, second_d_r;
  logic first_rise, first_fall, second_rise, second_fall;
  flpci_state_e state_r;
  logic [27:0] tmr_r;
  logic [4:0] cnt_r;
  logic [3:0] ms_left_r;
  logic win_r;
  logic method_b_r;
  logic [12:0] pwm_r;
  logic [27:0] flash_tmr_r;
  logic timed_out_r;
  flpci_pkg::flpci_mode_e mode_nxt;
  logic [12:0] ratio_nxt;
  logic led_nxt;

  flpci_sync #(
    .WIDTH(4)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_d({i_multi_current, i_transmit_current_mask,
          i_second_control_input, i_first_control_input}),
    .o_q(pins_q)
  );

  assign first_in = pins_q[0];
  assign second_in = pins_q[1];
  assign mask = pins_q[2];
  assign multi = pins_q[3];
  assign first_rise = first_in & ~first_d_r;
  assign first_fall = ~first_in & first_d_r;
  assign second_rise = second_in & ~second_d_r;
  assign second_fall = ~second_in & second_d_r;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      first_d_r <= 1'b0;
      second_d_r <= 1'b0;
    end else if (i_ce) begin
      first_d_r <= first_in;
      second_d_r <= second_in;
    end
  end

  // Sequencing state, pulse counting and the shared cycle timer.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state_r <= ST_IDLE;
      tmr_r <= 28'h0000000;
      cnt_r <= 5'h00;
      ms_left_r <= 4'h0;
      win_r <= 1'b0;
      method_b_r <= 1'b0;
    end else if (i_ce) begin
      case (state_r)
        ST_IDLE: begin
          tmr_r <= 28'h0000000;
          cnt_r <= 5'h00;
          win_r <= 1'b0;
          if (!multi) begin
            state_r <= ST_DIRECT;
          end else if (second_rise && !first_in) begin
            method_b_r <= 1'b1;
            state_r <= ST_B_SETUP;
          end else if (first_rise) begin
            method_b_r <= 1'b0;
            state_r <= ST_A_WAIT;
          end
        end
        ST_A_WAIT: begin
          // The delay runs from the first rise of the first input.
          tmr_r <= tmr_r + 28'h0000001;
          if (second_rise && first_in) method_b_r <= 1'b0;
          if (first_fall) cnt_r <= flpci_inc(cnt_r);
          if (!first_in && !second_in && tmr_r > 28'h0000000 &&
              !first_fall) begin
            state_r <= ST_IDLE;
          end else if (tmr_r == 28'(START_DELAY_CYC - 1)) begin
            state_r <= ST_ACTIVE;
          end
        end
        ST_B_SETUP: begin
          if (first_fall) cnt_r <= flpci_inc(cnt_r);
          if (second_rise) state_r <= ST_ACTIVE;
        end
        ST_ACTIVE: begin
          // Method B ends with the strobe; method A with both inputs low.
          if (method_b_r && !second_in) state_r <= ST_IDLE;
          else if (!method_b_r && !first_in && !second_in) begin
            state_r <= ST_IDLE;
          end
        end
        ST_DIRECT: begin
          if (multi) begin
            state_r <= ST_IDLE;
          end else if (first_in) begin
            cnt_r <= 5'h00;
            win_r <= 1'b0;
          end else begin
            if (second_fall) begin
              cnt_r <= flpci_inc(cnt_r);
              if (!win_r) begin
                win_r <= 1'b1;
                tmr_r <= 28'h0000000;
              end
            end
            if (win_r) tmr_r <= tmr_r + 28'h0000001;
            // A train of NOISE_MAX falls or fewer, or with the second input high, is dropped when its window ends.
            if (win_r && tmr_r == 28'(SETUP_WIN_CYC - 1)) begin
              win_r <= 1'b0;
              cnt_r <= 5'h00;
              if (cnt_r > flpci_pkg::NOISE_MAX && !second_in) begin
                ms_left_r <= 4'(cnt_r - flpci_pkg::NOISE_MAX);
                tmr_r <= 28'h0000000;
                state_r <= ST_TIMED;
              end
            end
          end
        end
        ST_TIMED: begin
          if (tmr_r == 28'(MS_CYC - 1)) begin
            tmr_r <= 28'h0000000;
            ms_left_r <= ms_left_r - 4'h1;
            if (ms_left_r == 4'h1) state_r <= ST_DIRECT;
          end else begin
            tmr_r <= tmr_r + 28'h0000001;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Free-running indicator pattern counter.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      pwm_r <= 13'h0000;
    end else if (i_ce) begin
      if (pwm_r == 13'(flpci_pkg::IND_PERIOD_CYC - 1)) pwm_r <= 13'h0000;
      else pwm_r <= pwm_r + 13'h0001;
    end
  end

  always_comb begin
    mode_nxt = flpci_pkg::MODE_OFF;
    ratio_nxt = 13'h0000;
    case (state_r)
      ST_ACTIVE: begin
        mode_nxt = flpci_decode(cnt_r);
        ratio_nxt = flpci_ratio(cnt_r);
      end
      ST_DIRECT: begin
        case ({second_in, first_in})
          2'b01: mode_nxt = flpci_pkg::MODE_IND;
          2'b10: mode_nxt = flpci_pkg::MODE_TORCH;
          2'b11: mode_nxt = flpci_pkg::MODE_FLASH;
          default: mode_nxt = flpci_pkg::MODE_OFF;
        endcase
        case ({second_in, first_in})
          2'b01: ratio_nxt = flpci_pkg::IND_RATIO;
          2'b10: ratio_nxt = flpci_pkg::TORCH_RATIO;
          2'b11: ratio_nxt = flpci_ratio(flpci_pkg::COUNT_SAT);
          default: ratio_nxt = 13'h0000;
        endcase
      end
      ST_TIMED: begin
        mode_nxt = flpci_pkg::MODE_TORCH;
        ratio_nxt = flpci_pkg::TORCH_RATIO;
      end
      default: begin
        mode_nxt = flpci_pkg::MODE_OFF;
        ratio_nxt = 13'h0000;
      end
    endcase
    led_nxt = (mode_nxt != flpci_pkg::MODE_OFF);
    if (mode_nxt == flpci_pkg::MODE_IND) begin
      led_nxt = (pwm_r < 13'(flpci_pkg::IND_ON_CYC));
    end
    if (mode_nxt == flpci_pkg::MODE_FLASH && timed_out_r) begin
      led_nxt = 1'b0;
    end
  end

  // The limit counts flash time only; the mask input never enters here.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      flash_tmr_r <= 28'h0000000;
      timed_out_r <= 1'b0;
    end else if (i_ce) begin
      if (mode_nxt != flpci_pkg::MODE_FLASH) begin
        flash_tmr_r <= 28'h0000000;
        timed_out_r <= 1'b0;
      end else if (!timed_out_r) begin
        flash_tmr_r <= flash_tmr_r + 28'h0000001;
        if (flash_tmr_r == 28'(FLASH_LIMIT_CYC - 1)) begin
          timed_out_r <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_led_on <= 1'b0;
      o_mode <= 2'b00;
      o_ratio <= 13'h0000;
      o_current_reduced <= 1'b0;
      o_method_b <= 1'b0;
      o_pulse_count <= 5'h00;
      o_flash_timed_out <= 1'b0;
    end else if (i_ce) begin
      o_led_on <= led_nxt;
      o_mode <= mode_nxt;
      o_ratio <= ratio_nxt;
      o_current_reduced <= mask;
      o_method_b <= method_b_r;
      o_pulse_count <= cnt_r;
      // The flag drops with flash mode, so it never stands beside a lit
      // torch or indicator in the cycle after flash is left.
      o_flash_timed_out <= timed_out_r && (mode_nxt == flpci_pkg::MODE_FLASH);
    end
  end
endmodule

// ---- sim/flpci_top_props.sv ----
// Purpose: Port-level checker for flpci_top.
// Assumes: The host holds every pin level far longer than the sync delay.
// Notes: Bound to every flpci_top instance; long counts use helper counters.
`timescale 1ns/1ps
module flpci_top_props #(
  parameter int FLASH_LIMIT_CYC = 2000
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_first_control_input,
  input wire logic i_second_control_input,
  input wire logic i_transmit_current_mask,
  input wire logic i_multi_current,
  input wire logic o_led_on,
  input wire logic [1:0] o_mode,
  input wire logic [12:0] o_ratio,
  input wire logic o_current_reduced,
  input wire logic o_method_b,
  input wire logic [4:0] o_pulse_count,
  input wire logic o_flash_timed_out
);
  logic [8:0] on_cnt_r;
  logic [31:0] fl_cnt_r;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // Timed indicator uses the torch mode code and torch ratio; only the low indicator ratio counts here.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst || !o_led_on || o_ratio != flpci_pkg::IND_RATIO) begin
      on_cnt_r <= 9'h000;
    end else if (on_cnt_r != 9'h1ff) begin
      on_cnt_r <= on_cnt_r + 9'h001;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst || o_mode != flpci_pkg::MODE_FLASH) begin
      fl_cnt_r <= 32'h0;
    end else if (o_led_on) begin
      fl_cnt_r <= fl_cnt_r + 32'h1;
    end
  end
  sequence seq_mask_up;
    $rose(i_transmit_current_mask);
  endsequence
  sequence seq_ind_fall;
    $fell(o_led_on) && o_mode == flpci_pkg::MODE_IND;
  endsequence
  chk_mask_copy: assert property (
    seq_mask_up |-> ##[1:5] o_current_reduced)
    else $error("mask not reported");
  chk_off_dark: assert property (
    o_mode == flpci_pkg::MODE_OFF |-> !o_led_on && o_ratio == 13'h0000)
    else $error("off mode drives current");
  chk_ind_ratio: assert property (
    o_mode == flpci_pkg::MODE_IND && i_multi_current
    |-> o_ratio == flpci_pkg::IND_RATIO)
    else $error("indicator ratio wrong");
  chk_torch_ratio: assert property (
    o_mode == flpci_pkg::MODE_TORCH && i_multi_current
    |-> o_ratio inside {13'h01c0, 13'h03a1, 13'h0582, 13'h0763})
    else $error("torch ratio wrong");
  chk_flash_ratio: assert property (
    o_mode == flpci_pkg::MODE_FLASH |-> o_ratio >= 13'h0943)
    else $error("flash ratio too low");
  chk_ind_on_len: assert property (
    on_cnt_r <= flpci_pkg::IND_ON_CYC)
    else $error("indicator on phase too long");
  chk_ind_off_gap: assert property (
    seq_ind_fall |=> (!o_led_on || o_mode != flpci_pkg::MODE_IND)[*8])
    else $error("indicator off phase too short");
  chk_flash_limit: assert property (
    fl_cnt_r <= FLASH_LIMIT_CYC)
    else $error("flash ran past limit");
  chk_timeout_dark: assert property (
    o_flash_timed_out |-> !o_led_on)
    else $error("led on after timeout");
  chk_count_sat: assert property (
    o_pulse_count <= 5'h11)
    else $error("pulse count above ceiling");
  chk_b_first_low: assert property (
    $rose(o_method_b) |-> !i_first_control_input)
    else $error("method b with first input high");
  chk_b_strobe: assert property (
    (o_method_b && i_multi_current && !i_second_control_input) [*8]
    |-> !o_led_on)
    else $error("led on without strobe");
endmodule
bind flpci_top flpci_top_props #(.FLASH_LIMIT_CYC(FLASH_LIMIT_CYC))
  u_props (.*);

// ---- sim/flpci_host_model.sv ----
// Purpose: Host that drives the two control pins.
// Assumes: Pins change only at the falling clock edge.
// Notes: Every level is held for the minimum width before the next change.
`timescale 1ns/1ps
module flpci_host_model #(
  parameter int W = 200
) (
  input wire logic i_clk,
  output logic o_first,
  output logic o_second
);
  initial begin
    o_first = 1'b0;
    o_second = 1'b0;
  end
  task automatic drive(input logic f, input logic s);
    @(negedge i_clk);
    o_first = f;
    o_second = s;
    repeat (W - 1) @(negedge i_clk);
  endtask
  // Toggles one pin 2n times, giving n falls; the other pin stays put.
  task automatic toggle(input bit on_second, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      if (on_second) begin
        drive(o_first, ~o_second);
      end else begin
        drive(~o_first, o_second);
      end
    end
  endtask
endmodule

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for flpci_top.
// Assumes: Shortened counts; ms step 50, flash limit 2000 cycles.
// Notes: Setup window and start delay exceed the longest method A or timed indicator train.
`timescale 1ns/1ps
module tb_top;
  localparam int W = 200;
  localparam int MSC = 50;
  localparam int FLC = 2000;
  localparam int WIN = 7500;
  logic i_core_clk, i_nrst, mask, multi, first, second;
  logic led, cur_red, meth_b, tout;
  logic [1:0] mode;
  logic [12:0] ratio;
  logic [4:0] cnt;
  int err_count, total_checks, cyc, seed, n, t0, on_n, e;
  int cb[5] = '{0, 1, 5, 6, 20};
  int tk[3] = '{2, 3, 18};
  logic [12:0] tbl[16] = '{13'h01c0, 13'h03a1, 13'h0582, 13'h0763,
    13'h0943, 13'h0b24, 13'h0d05, 13'h0ee6, 13'h10c7, 13'h12a8,
    13'h1489, 13'h1669, 13'h184a, 13'h1a2b, 13'h1c0c, 13'h1de2};
  flpci_host_model #(.W(W)) host (.i_clk(i_core_clk), .o_first(first),
    .o_second(second));
  flpci_top #(.MS_CYC(MSC), .FLASH_LIMIT_CYC(FLC), .SETUP_WIN_CYC(WIN),
    .START_DELAY_CYC(WIN)) DUT (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_ce(1'b1), .i_first_control_input(first),
    .i_second_control_input(second), .i_transmit_current_mask(mask),
    .i_multi_current(multi), .o_led_on(led), .o_mode(mode),
    .o_ratio(ratio), .o_current_reduced(cur_red), .o_method_b(meth_b),
    .o_pulse_count(cnt), .o_flash_timed_out(tout));
  function automatic logic [12:0] exp_ratio(input int c);
    if (c < 2) return flpci_pkg::IND_RATIO;
    return tbl[(c > 17 ? 17 : c) - 2];
  endfunction
  function automatic logic [1:0] exp_mode(input int c);
    if (c < 2) return flpci_pkg::MODE_IND;
    return (c < 6) ? flpci_pkg::MODE_TORCH : flpci_pkg::MODE_FLASH;
  endfunction
  task automatic chk(input string nm, input logic [12:0] x, g);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("unexpected %s: expected %0d, seen %0d", nm, x, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic run_b(input int c);
    host.drive(1'b0, 1'b0);
    host.drive(1'b0, 1'b1);
    chk("method_b", 13'h0001, meth_b);
    host.toggle(1'b0, c);
    chk("count", c > 17 ? 17 : c, cnt);
    host.drive(1'b0, 1'b0);
    chk("led before strobe", 13'h0000, led);
    mask = $random(seed);
    host.drive(1'b0, 1'b1);
    chk("mode", exp_mode(c), mode);
    chk("ratio", exp_ratio(c), ratio);
    if (c >= 2) chk("led in strobe", 13'h0001, led);
    chk("mask copy", mask, cur_red);
    if (c >= 6) begin
      repeat (FLC) @(negedge i_core_clk);
      chk("timed out", 13'h0001, tout);
    end
    host.drive(1'b0, 1'b0);
    chk("led after strobe", 13'h0000, led);
    $display("test method b count %0d done", c);
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc > 100000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    seed = 32'h542c;
    i_nrst = 1'b0;
    mask = 1'b0;
    multi = 1'b1;
    repeat (4) @(negedge i_core_clk);
    i_nrst = 1'b1;
    for (int k = 0; k < 6; k++) begin
      n = (k < 5) ? cb[k] : 2 + {$random(seed)} % 15;
      run_b(n);
    end
    n = 3 + {$random(seed)} % 14;
    host.drive(1'b0, 1'b0);
    host.drive(1'b1, 1'b0);
    t0 = cyc - W;
    host.drive(1'b1, 1'b1);
    chk("method_b", 13'h0000, meth_b);
    host.toggle(1'b0, n);
    while (cyc < t0 + WIN - 10) @(negedge i_core_clk);
    chk("mode early", 13'h0000, mode);
    while (cyc < t0 + WIN + 10) @(negedge i_core_clk);
    chk("mode a", exp_mode(n), mode);
    chk("ratio a", exp_ratio(n), ratio);
    host.drive(1'b0, 1'b0);
    $display("test method a count %0d done", n);
    multi = 1'b0;
    host.drive(1'b1, 1'b0);
    on_n = 0;
    repeat (6400) begin
      @(negedge i_core_clk);
      on_n += led;
    end
    chk("indicator on cycles", 13'h00c8, on_n);
    mask = $random(seed);
    host.drive(1'b1, 1'b1);
    repeat (FLC) @(negedge i_core_clk);
    chk("direct timed out", 13'h0001, tout);
    // Drop the second input while the first is still high, so that the
    // fall is not taken as the start of a timed indicator train.
    host.drive(1'b1, 1'b0);
    chk("timeout cleared", 13'h0000, tout);
    host.drive(1'b0, 1'b0);
    $display("test direct modes done");
    // Trains stay inside the setup window, as the host must.
    foreach (tk[k]) begin
      host.toggle(1'b1, tk[k]);
      on_n = 0;
      repeat (WIN + 800) begin
        @(negedge i_core_clk);
        on_n += led;
      end
      e = (tk[k] < 3) ? 0 : ((tk[k] > 17 ? 17 : tk[k]) - 2) * MSC;
      if (on_n >= e - 2 && on_n <= e + 2) on_n = e;
      chk("timed length", e, on_n);
      $display("test timed indicator %0d falls done", tk[k]);
    end
    wrap_up();
  end
endmodule
